/* logic/pcg_pkg.sv */
package pcg_pkg;
  localparam logic [11:0] OFS_PORT_CFG     = 12'h300;
  localparam logic [11:0] OFS_CLK_GATE     = 12'h314;
  localparam logic [11:0] OFS_LANE_STN0    = 12'h330;
  localparam logic [11:0] OFS_LANE_STN45   = 12'h338;

  localparam logic [31:0] MASK_PORT_CFG    = 32'h0000_0F03;
  localparam logic [31:0] MASK_CLK_GATE    = 32'h18FF_000F;
  localparam logic [31:0] MASK_LANE_STN0   = 32'h0000_FFFF;
  localparam logic [31:0] RST_CLK_GATE     = 32'h18FF_000F;
  localparam logic [31:0] RST_PORT_CFG     = 32'h0000_0000;

  localparam int          CFG_STN0_LSB     = 0;
  localparam int          CFG_STN4_LSB     = 8;
  localparam int          CFG_STN5_LSB     = 10;
  localparam int          BIT_PORT0        = 0;
  localparam int          BIT_PORT1        = 1;
  localparam int          BIT_PORT16       = 16;
  localparam int          BIT_PORT17       = 17;
  localparam int          BIT_PORT20       = 20;
  localparam int          BIT_PORT21       = 21;
  localparam int          BIT_ROOT4        = 27;
  localparam int          BIT_ROOT5        = 28;

  localparam int          NUM_LANES        = 48;
  localparam int          LANE_STN0_W      = 16;
  localparam int          LANE_HI_BASE     = 32;
  localparam int          LANE_MID_BASE    = 16;
  localparam logic [47:0] RST_LANE_FLAGS   = 48'hFFFF_FFFF_FFFF;

  localparam int          NUM_SRC          = 3;
  localparam int          SRC_PORT0        = 0;
  localparam int          SRC_NT_VIRT      = 1;
  localparam int          SRC_MGMT         = 2;
  localparam logic [1:0]  SYNC_WAIT_CYC    = 2'h3;

  typedef enum logic [1:0] {PH_SYNC, PH_LOAD, PH_SEED, PH_RUN} pcg_phase_type;
endpackage

/* logic/pcg_wr_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pcg_wr_if;
  logic        wr_stn0;
  logic        wr_stn45;
  logic [31:0] wdata;
  modport src (output wr_stn0, output wr_stn45, output wdata);
  modport dst (input wr_stn0, input wr_stn45, input wdata);
endinterface : pcg_wr_if
`default_nettype wire

/* logic/pcg_strap_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pcg_strap_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,      // core clock
  input  wire logic             sys_rst,  // fundamental reset
  input  wire logic [WIDTH-1:0] pin_in,   // raw strap pins
  output logic      [WIDTH-1:0] pin_out   // synchronised straps
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
    end
  end

  assign pin_out = stage2;
endmodule // pcg_strap_sync
`default_nettype wire

/* logic/pcg_lane_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module pcg_lane_bank #(
  parameter int LANES = 48
) (
  input  wire logic             clk,      // core clock
  input  wire logic             sys_rst,  // fundamental reset
  input  wire logic [LANES-1:0] lane_up,  // per-lane up from physical layer
  pcg_wr_if.dst                 wr,       // software writes
  output logic      [LANES-1:0] flags     // lane-up status bits
);
  logic [LANES-1:0] up_d;
  logic [LANES-1:0] next_flags;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic sw_hit;
      logic sw_val;
      if (g < pcg_pkg::LANE_STN0_W) begin : g_s0
        assign sw_hit = wr.wr_stn0;
        assign sw_val = wr.wdata[g];
      end else if (g < pcg_pkg::LANE_HI_BASE) begin : g_mid
        assign sw_hit = wr.wr_stn45;
        assign sw_val = wr.wdata[g];
      end else begin : g_hi
        assign sw_hit = wr.wr_stn45;
        assign sw_val = wr.wdata[g - pcg_pkg::LANE_HI_BASE];
      end
      // lane edge wins over a software write in the same cycle
      always_comb begin
        next_flags[g] = flags[g];
        if (sw_hit)
          next_flags[g] = sw_val;
        if (lane_up[g] && !up_d[g])
          next_flags[g] = 1'b1;
        else if (!lane_up[g] && up_d[g])
          next_flags[g] = 1'b0;
      end
    end
  endgenerate

  // sticky: of the resets only the fundamental reset returns the bits to up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= pcg_pkg::RST_LANE_FLAGS;
      up_d  <= pcg_pkg::RST_LANE_FLAGS;
    end else begin
      flags <= next_flags;
      up_d  <= lane_up;
    end
  end
endmodule // pcg_lane_bank
`default_nettype wire

/* logic/pcg_top.sv */
// Overview of operation
// - after reset, port enables follow width straps unless EEPROM config overrides them
// - cleared clock-enable bit stops that port's clock, disabling it
// - never enable more ports than the configuration allows
// - clock-enable bit 0 disables, 1 enables; port 0 bit resets to 1
// - port 1..3 enable reset values follow station 0 width config
// - port 17..19 enable reset values follow station 4 width config
// - port 21..23 enable reset values follow station 5 width config
// - port 16 and 20 bits sit at 16 and 20, reset to 1
// - station 4/5 root clock enables at bits 27, 28, reset 1, writable
// - station 0 lane word: one up bit per lane, reset to 1
// - registers reached via port 0, nontransparent interface, or management port by mode
// - station 4/5 lane word: lanes 32-47 low half, 16-31 high half
// - width configuration fields reset only by fundamental reset
`timescale 1ns/10ps
`default_nettype none
module pcg_top (
  input  wire logic        clk,              // core clock, 250 MHz
  input  wire logic        sys_rst,          // fundamental reset, async high
  input  wire logic        hot_rst,          // lesser reset, same-clock pulse
  input  wire logic [1:0]  station0_width_strap, // station 0 width strap pins
  input  wire logic [1:0]  station4_width_strap, // station 4 width strap pins
  input  wire logic [1:0]  station5_width_strap, // station 5 width strap pins
  input  wire logic        vswitch_strap,    // virtual switch mode strap pin
  input  wire logic        port0_nontransparent_strap, // port 0 legacy nontransparent pin
  input  wire logic [2:0]  acc_req,          // per-source register request
  input  wire logic [2:0]  acc_wr,           // per-source write, else read
  input  wire logic [35:0] acc_addr,         // per-source byte offset, 12 bits each
  input  wire logic [95:0] acc_wdata,        // per-source write data, 32 bits each
  output logic             acc_ack,          // answer pulse for accepted request
  output logic      [31:0] acc_rdata,        // read data with acc_ack
  input  wire logic        ee_wr,            // EEPROM or I2C register write
  input  wire logic [11:0] ee_addr,          // EEPROM or I2C byte offset
  input  wire logic [31:0] ee_wdata,         // EEPROM or I2C write data
  input  wire logic        ee_done,          // EEPROM load finished or absent
  input  wire logic [47:0] lane_up,          // per-lane up from physical layer
  output logic      [23:0] port_clk_en,      // effective per-port clock enable
  output logic             stn4_root_en,     // station 4 root clock enable
  output logic             stn5_root_en,     // station 5 root clock enable
  output logic             cfg_ready         // seeding finished
);
  logic [7:0]  strap_s;
  logic [1:0]  st0_w;
  logic [1:0]  st4_w;
  logic [1:0]  st5_w;
  logic        vs_mode;
  logic        nt_port0;

  pcg_strap_sync #(.WIDTH(8)) u_strap (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  ({port0_nontransparent_strap, vswitch_strap, station5_width_strap,
               station4_width_strap, station0_width_strap}),
    .pin_out (strap_s)
  );
  assign st0_w    = strap_s[1:0];
  assign st4_w    = strap_s[3:2];
  assign st5_w    = strap_s[5:4];
  assign vs_mode  = strap_s[6];
  assign nt_port0 = strap_s[7];

  // enables for the three non-register ports of a station, by width code
  // 00 x4x4x4x4, 01 x16, 10 x8x8, 11 x8x4x4
  function automatic logic [2:0] peer_mask(input logic [1:0] code);
    case (code)
      2'h0:    peer_mask = 3'h7;
      2'h1:    peer_mask = 3'h0;
      2'h2:    peer_mask = 3'h2;
      2'h3:    peer_mask = 3'h6;
      default: peer_mask = 3'h0;
    endcase
  endfunction

  // ---------------- access source selection
  pcg_pkg::pcg_phase_type phase;
  pcg_pkg::pcg_phase_type next_phase;
  logic [1:0]  wait_cnt;
  logic [1:0]  next_wait_cnt;
  int unsigned sel_src;
  logic        req;
  logic        req_wr;
  logic [11:0] req_addr;
  logic [31:0] req_wdata;

  // mode straps are synchronised but not latched; a mode change moves the bus at once
  always_comb begin
    if (vs_mode)
      sel_src = pcg_pkg::SRC_MGMT;
    else if (nt_port0)
      sel_src = pcg_pkg::SRC_NT_VIRT;
    else
      sel_src = pcg_pkg::SRC_PORT0;
  end

  // other sources get no answer; straps are not trusted until seeding ends
  assign req       = acc_req[sel_src] && (phase == pcg_pkg::PH_RUN);
  assign req_wr    = acc_wr[sel_src];
  assign req_addr  = acc_addr[sel_src*12 +: 12];
  assign req_wdata = acc_wdata[sel_src*32 +: 32];

  // ---------------- write decode
  // one decode per target keeps loader and bus priority in a single place
  localparam int BIT_P1  = pcg_pkg::BIT_PORT1;
  localparam int BIT_P17 = pcg_pkg::BIT_PORT17;
  localparam int BIT_P21 = pcg_pkg::BIT_PORT21;

  logic        ee_live;
  logic        sw_wr_gate;
  logic        sw_wr_lane0;
  logic        sw_wr_lane45;
  logic        ee_wr_cfg;
  logic        ee_wr_gate;
  logic        ee_wr_lane0;
  logic        ee_wr_lane45;

  // loader writes to the width and gate words are dropped until the straps are captured
  assign ee_live      = (phase != pcg_pkg::PH_SYNC);
  assign sw_wr_gate   = req && req_wr && (req_addr == pcg_pkg::OFS_CLK_GATE);
  assign sw_wr_lane0  = req && req_wr && (req_addr == pcg_pkg::OFS_LANE_STN0);
  assign sw_wr_lane45 = req && req_wr && (req_addr == pcg_pkg::OFS_LANE_STN45);
  assign ee_wr_cfg    = ee_wr && ee_live && (ee_addr == pcg_pkg::OFS_PORT_CFG);
  assign ee_wr_gate   = ee_wr && ee_live && (ee_addr == pcg_pkg::OFS_CLK_GATE);
  assign ee_wr_lane0  = ee_wr && (ee_addr == pcg_pkg::OFS_LANE_STN0);
  assign ee_wr_lane45 = ee_wr && (ee_addr == pcg_pkg::OFS_LANE_STN45);

  // ---------------- width configuration, fundamental reset only
  logic [31:0] port_cfg;
  logic [31:0] next_port_cfg;

  always_comb begin
    next_port_cfg = port_cfg;
    if (phase == pcg_pkg::PH_SYNC && wait_cnt == pcg_pkg::SYNC_WAIT_CYC) begin
      next_port_cfg = '0;
      next_port_cfg[pcg_pkg::CFG_STN0_LSB +: 2] = st0_w;
      next_port_cfg[pcg_pkg::CFG_STN4_LSB +: 2] = st4_w;
      next_port_cfg[pcg_pkg::CFG_STN5_LSB +: 2] = st5_w;
    end
    // EEPROM values written after strap capture override the straps
    if (ee_wr_cfg)
      next_port_cfg = ee_wdata & pcg_pkg::MASK_PORT_CFG;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      port_cfg <= pcg_pkg::RST_PORT_CFG;
    else
      port_cfg <= next_port_cfg;
  end

  // ---------------- seeding sequence
  always_comb begin
    next_phase    = phase;
    next_wait_cnt = wait_cnt;
    case (phase)
      pcg_pkg::PH_SYNC: begin
        next_wait_cnt = wait_cnt + 2'h1;
        if (wait_cnt == pcg_pkg::SYNC_WAIT_CYC)
          next_phase = pcg_pkg::PH_LOAD;
      end
      // no timeout here: without a loader the done input must be tied high
      pcg_pkg::PH_LOAD:
        if (ee_done)
          next_phase = pcg_pkg::PH_SEED;
      pcg_pkg::PH_SEED:
        next_phase = pcg_pkg::PH_RUN;
      pcg_pkg::PH_RUN:
        next_phase = pcg_pkg::PH_RUN;
      default:
        next_phase = pcg_pkg::PH_SYNC;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase    <= pcg_pkg::PH_SYNC;
      wait_cnt <= 2'h0;
    end else begin
      phase    <= next_phase;
      wait_cnt <= next_wait_cnt;
    end
  end

  // ---------------- clock gate register
  logic [31:0] clk_gate;
  logic [31:0] next_clk_gate;

  always_comb begin
    next_clk_gate = clk_gate;
    // seeded only here: a later width write moves the ceiling, not the enables
    if (phase == pcg_pkg::PH_SEED) begin
      next_clk_gate = pcg_pkg::RST_CLK_GATE;
      next_clk_gate[BIT_P1 +: 3]  = peer_mask(port_cfg[pcg_pkg::CFG_STN0_LSB +: 2]);
      next_clk_gate[BIT_P17 +: 3] = peer_mask(port_cfg[pcg_pkg::CFG_STN4_LSB +: 2]);
      next_clk_gate[BIT_P21 +: 3] = peer_mask(port_cfg[pcg_pkg::CFG_STN5_LSB +: 2]);
    end
    if (sw_wr_gate)
      next_clk_gate = req_wdata & pcg_pkg::MASK_CLK_GATE;
    // loader write lands last so it wins over a software write
    if (ee_wr_gate)
      next_clk_gate = ee_wdata & pcg_pkg::MASK_CLK_GATE;
  end

  // sticky: the lesser reset leaves the enables alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      clk_gate <= pcg_pkg::RST_CLK_GATE;
    else
      clk_gate <= next_clk_gate;
  end

  // ---------------- effective enables
  // a root bit low starves its whole station, register port included
  logic [23:0] allowed;
  logic [23:0] next_port_en;
  logic        next_root4;
  logic        next_root5;

  always_comb begin
    allowed = '0;
    allowed[pcg_pkg::BIT_PORT0]    = 1'b1;
    allowed[BIT_P1 +: 3]           = peer_mask(port_cfg[pcg_pkg::CFG_STN0_LSB +: 2]);
    allowed[pcg_pkg::BIT_PORT16]   = clk_gate[pcg_pkg::BIT_ROOT4];
    allowed[BIT_P17 +: 3]          = peer_mask(port_cfg[pcg_pkg::CFG_STN4_LSB +: 2])
                                     & {3{clk_gate[pcg_pkg::BIT_ROOT4]}};
    allowed[pcg_pkg::BIT_PORT20]   = clk_gate[pcg_pkg::BIT_ROOT5];
    allowed[BIT_P21 +: 3]          = peer_mask(port_cfg[pcg_pkg::CFG_STN5_LSB +: 2])
                                     & {3{clk_gate[pcg_pkg::BIT_ROOT5]}};
    // the width configuration sets the ceiling; extra set bits gain nothing
    next_port_en = '0;
    next_root4   = 1'b0;
    next_root5   = 1'b0;
    if (phase == pcg_pkg::PH_RUN) begin
      next_port_en = clk_gate[23:0] & allowed;
      next_root4   = clk_gate[pcg_pkg::BIT_ROOT4];
      next_root5   = clk_gate[pcg_pkg::BIT_ROOT5];
    end
  end

  // registered so the port clock gates never see decode glitches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_clk_en  <= '0;
      stn4_root_en <= 1'b0;
      stn5_root_en <= 1'b0;
      cfg_ready    <= 1'b0;
    end else begin
      port_clk_en  <= next_port_en;
      stn4_root_en <= next_root4;
      stn5_root_en <= next_root5;
      cfg_ready    <= (phase == pcg_pkg::PH_RUN);
    end
  end

  // ---------------- lane status bank
  pcg_wr_if lane_wr ();
  logic [47:0] lane_flags;

  // a loader write takes the data path over a same-cycle bus write
  assign lane_wr.wr_stn0  = sw_wr_lane0 || ee_wr_lane0;
  assign lane_wr.wr_stn45 = sw_wr_lane45 || ee_wr_lane45;
  assign lane_wr.wdata    = (ee_wr_lane0 || ee_wr_lane45) ? ee_wdata : req_wdata;

  pcg_lane_bank #(.LANES(pcg_pkg::NUM_LANES)) u_lanes (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lane_up (lane_up),
    .wr      (lane_wr),
    .flags   (lane_flags)
  );

  // ---------------- read answer
  logic [31:0] rd_mux;
  logic        next_ack;
  logic [31:0] next_rdata;

  always_comb begin
    case (req_addr)
      pcg_pkg::OFS_PORT_CFG:   rd_mux = port_cfg & pcg_pkg::MASK_PORT_CFG;
      pcg_pkg::OFS_CLK_GATE:   rd_mux = clk_gate & pcg_pkg::MASK_CLK_GATE;
      pcg_pkg::OFS_LANE_STN0:  rd_mux = {16'h0000, lane_flags[15:0]};
      pcg_pkg::OFS_LANE_STN45: rd_mux = {lane_flags[31:16], lane_flags[47:32]};
      default:                 rd_mux = 32'h0000_0000;
    endcase
    // a lesser reset swallows the answer, but a write in that cycle still lands
    next_ack   = req && !hot_rst;
    next_rdata = 32'h0000_0000;
    if (req && !req_wr && !hot_rst)
      next_rdata = rd_mux;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ack   <= 1'b0;
      acc_rdata <= 32'h0000_0000;
    end else begin
      acc_ack   <= next_ack;
      acc_rdata <= next_rdata;
    end
  end
endmodule // pcg_top
`default_nettype wire

/* dv/pcg_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module pcg_top_props (
  input  wire logic        clk,                        // core clock
  input  wire logic        sys_rst,                    // fundamental reset
  input  wire logic        hot_rst,                    // lesser reset
  input  wire logic        vswitch_strap,              // mode strap
  input  wire logic        port0_nontransparent_strap, // base-mode source strap
  input  wire logic [2:0]  acc_req,                    // requests
  input  wire logic [2:0]  acc_wr,                     // write flags
  input  wire logic [35:0] acc_addr,                   // offsets
  input  wire logic [95:0] acc_wdata,                  // write data
  input  wire logic        acc_ack,                    // answer pulse
  input  wire logic [31:0] acc_rdata,                  // read data
  input  wire logic [23:0] port_clk_en,                // effective enables
  input  wire logic        stn4_root_en,               // station 4 root
  input  wire logic        stn5_root_en,               // station 5 root
  input  wire logic        cfg_ready                   // seeding done
);
  logic [1:0]  sel;
  logic        req_ok;
  logic        wr_sel;
  logic [11:0] a_sel;
  logic [31:0] d_sel;
  // raw straps: bench keeps the bus idle while a mode change syncs in
  assign sel    = vswitch_strap ? 2'h2 : {1'b0, port0_nontransparent_strap};
  assign req_ok = acc_req[sel] && cfg_ready && !hot_rst;
  assign wr_sel = acc_wr[sel];
  assign a_sel  = acc_addr[12*sel +: 12];
  assign d_sel  = acc_wdata[32*sel +: 32];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_port0_on; cfg_ready |-> port_clk_en[0]; endproperty
  property p_gap_off; port_clk_en[15:4] == 12'h000; endproperty
  property p_ack_src; acc_ack |-> $past(req_ok); endproperty
  property p_ack_due; req_ok |=> acc_ack; endproperty
  property p_wr_zero; acc_ack && $past(wr_sel) |-> acc_rdata == 32'h0000_0000; endproperty
  property p_ready_hold; cfg_ready |=> cfg_ready; endproperty
  property p_root4; |port_clk_en[19:16] |-> stn4_root_en; endproperty
  property p_root5; |port_clk_en[23:20] |-> stn5_root_en; endproperty
  property p_clear_stops;
    req_ok && wr_sel && a_sel == 12'h314 && !d_sel[3] |-> ##2 !port_clk_en[3];
  endproperty
  a_port0_on: assert property (p_port0_on) else $error("port 0 enable dropped");
  a_gap_off: assert property (p_gap_off) else $error("unused port enabled");
  a_ack_src: assert property (p_ack_src) else $error("answer without request");
  a_ack_due: assert property (p_ack_due) else $error("request not answered");
  a_wr_zero: assert property (p_wr_zero) else $error("write answer data not zero");
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  a_root4: assert property (p_root4) else $error("station 4 port without root");
  a_root5: assert property (p_root5) else $error("station 5 port without root");
  a_clear_stops: assert property (p_clear_stops) else $error("cleared port runs");
  c_wr_ack: cover property (acc_ack && $past(wr_sel));
  c_gate: cover property ($fell(port_clk_en[3]));
  c_hot: cover property (hot_rst && acc_req[sel]);
endmodule // pcg_top_props

bind pcg_top pcg_top_props u_pcg_props (
  .clk(clk), .sys_rst(sys_rst), .hot_rst(hot_rst), .vswitch_strap(vswitch_strap),
  .port0_nontransparent_strap(port0_nontransparent_strap), .acc_req(acc_req),
  .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
  .acc_rdata(acc_rdata), .port_clk_en(port_clk_en), .stn4_root_en(stn4_root_en),
  .stn5_root_en(stn5_root_en), .cfg_ready(cfg_ready));
`default_nettype wire

/* dv/tb_pcg_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pcg_top;
  logic        clk, sys_rst, hot_rst, vswitch_strap, port0_nontransparent_strap;
  logic [1:0]  station0_width_strap, station4_width_strap, station5_width_strap;
  logic [2:0]  acc_req, acc_wr;
  logic [35:0] acc_addr;
  logic [95:0] acc_wdata;
  logic        acc_ack, ee_wr, ee_done, stn4_root_en, stn5_root_en, cfg_ready;
  logic [31:0] acc_rdata, ee_wdata, rd;
  logic [11:0] ee_addr;
  logic [47:0] lane_up;
  logic [23:0] port_clk_en;
  int          error_cnt, compares, sel;

  pcg_top dut (.clk(clk), .sys_rst(sys_rst), .hot_rst(hot_rst),
    .station0_width_strap(station0_width_strap), .station4_width_strap(station4_width_strap),
    .station5_width_strap(station5_width_strap), .vswitch_strap(vswitch_strap),
    .port0_nontransparent_strap(port0_nontransparent_strap), .acc_req(acc_req),
    .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
    .acc_rdata(acc_rdata), .ee_wr(ee_wr), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .ee_done(ee_done), .lane_up(lane_up), .port_clk_en(port_clk_en),
    .stn4_root_en(stn4_root_en), .stn5_root_en(stn5_root_en), .cfg_ready(cfg_ready));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held over one taking edge; answer read at the next falling edge while it stands
  task automatic acc(input int s, input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic ack_exp, input logic hr);
    @(negedge clk);
    hot_rst = hr;
    acc_req[s] = 1'b1;
    acc_wr[s] = w;
    acc_addr[12*s +: 12] = a;
    acc_wdata[32*s +: 32] = d;
    @(negedge clk);
    chk("acc_ack", {31'h0, ack_exp}, {31'h0, acc_ack});
    rd = acc_rdata;
    hot_rst = 1'b0;
    acc_req = 3'h0;
    acc_wr = 3'h0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    acc(sel, 1'b0, a, 32'h0000_0000, 1'b1, 1'b0);
    chk(nm, exp, rd);
  endtask

  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    {sys_rst, hot_rst, vswitch_strap, port0_nontransparent_strap} = 4'h8;
    {acc_req, acc_wr, acc_addr, acc_wdata} = '0;
    {ee_wr, ee_done, ee_addr, ee_wdata} = '0;
    station0_width_strap = 2'h3;
    station4_width_strap = 2'h2;
    station5_width_strap = 2'h1;
    lane_up = 48'hFFFF_FFFF_FFFF;
    error_cnt = 0;
    compares = 0;
    sel = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    ee_wr = 1'b1;
    ee_addr = 12'h300;
    ee_wdata = 32'h0000_0203;
    @(negedge clk);
    ee_wr = 1'b0;
    repeat (3) @(negedge clk);
    chk("cfg_ready", 32'h0, {31'h0, cfg_ready});
    ee_done = 1'b1;
    for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++) @(negedge clk);
    chk("cfg_ready", 32'h1, {31'h0, cfg_ready});
    rdc("width_cfg", 12'h300, 32'h0000_0203);
    rdc("port_clock_gate", 12'h314, 32'h18F5_000D);
    chk("port_clk_en", 32'h00F5_000D, {8'h0, port_clk_en});
    rdc("station0_lane_up_flags", 12'h330, 32'h0000_FFFF);
    rdc("station45_lane_up_flags", 12'h338, 32'hFFFF_FFFF);
    acc(sel, 1'b1, 12'h314, 32'hFFFF_FFFF, 1'b1, 1'b0);
    rdc("port_clock_gate", 12'h314, 32'h18FF_000F);
    chk("port_clk_en", 32'h00F5_000D, {8'h0, port_clk_en});
    acc(sel, 1'b1, 12'h300, 32'h0000_0000, 1'b1, 1'b0);
    rdc("width_cfg", 12'h300, 32'h0000_0203);
    rdc("unmapped", 12'h3FC, 32'h0000_0000);
    acc(sel, 1'b1, 12'h314, 32'h0871_0005, 1'b1, 1'b0);
    @(negedge clk);
    chk("port_clk_en", 32'h0001_0005, {8'h0, port_clk_en});
    chk("root_en", 32'h1, {30'h0, stn5_root_en, stn4_root_en});
    acc(sel, 1'b0, 12'h314, 32'h0000_0000, 1'b0, 1'b1);
    rdc("port_clock_gate", 12'h314, 32'h0871_0005);
    @(negedge clk);
    lane_up[5] = 1'b0;
    lane_up[40] = 1'b0;
    lane_up[20] = 1'b0;
    rdc("station0_lane_up_flags", 12'h330, 32'h0000_FFDF);
    rdc("station45_lane_up_flags", 12'h338, 32'hFFEF_FEFF);
    lane_up = 48'hFFFF_FFFF_FFFF;
    rdc("station0_lane_up_flags", 12'h330, 32'h0000_FFFF);
    acc(sel, 1'b1, 12'h330, 32'hFFFF_0000, 1'b1, 1'b0);
    rdc("station0_lane_up_flags", 12'h330, 32'h0000_0000);
    for (int m = 0; m < 3; m++) begin
      vswitch_strap = (m == 2);
      port0_nontransparent_strap = (m == 1);
      repeat (4) @(negedge clk);
      sel = m;
      rdc("mode_read", 12'h314, 32'h0871_0005);
      acc((m + 1) % 3, 1'b0, 12'h314, 32'h0000_0000, 1'b0, 1'b0);
    end
    print_verdict();
  end
endmodule // tb_pcg_top
`default_nettype wire
